// *** src/mac_hdr_framer.sv ***
// MAC header builder and parser with frame classification and an AXI4-Lite register slave.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module mac_hdr_framer
(
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // AXI4-Lite register slave.
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Interrupt.
   output logic             irq,
   // Received byte stream from the link.
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   // Accepted PDU bytes toward the upper layer.
   output logic             pdu_valid,
   output logic [7:0]       pdu_data,
   output logic             pdu_first,
   output logic             pdu_last,
   output logic [7:0]       frame_control_byte,
   // Extended header and PDU bytes to transmit.
   input  wire logic        tx_in_valid,
   input  wire logic [7:0]  tx_in_data,
   input  wire logic        payload_header_squash,
   output logic             tx_in_ready,
   // Framed bytes toward the link.
   output logic             tx_out_valid,
   output logic [7:0]       tx_out_data,
   input  wire logic        tx_out_ready
);

   // Module state, apart from the reset release chain, in one record.
   typedef struct packed {
      mac_hdr_pkg::rx_state_type rx_st;
      logic [7:0]                fc;
      logic [7:0]                parm;
      logic [15:0]               len;
      logic [15:0]               cnt;
      logic [15:0]               crc;
      logic [7:0]                hcs_hi;
      logic                      keep;
      logic                      bfirst;
      logic                      o_v;
      logic [7:0]                o_d;
      logic                      o_first;
      logic                      o_last;
      mac_hdr_pkg::tx_state_type tx_st;
      logic [15:0]               tcrc;
      logic [15:0]               tcnt;
      logic                      t_v;
      logic [7:0]                t_d;
      logic [1:0]                ctrl;
      logic [31:0]               tx_hdr;
      logic [5:0]                sts;
      logic [5:0]                msk;
      logic                      aw_h;
      logic [5:0]                aw_a;
      logic                      w_h;
      logic [31:0]               w_d;
      logic [3:0]                w_s;
      logic                      b_v;
      logic [1:0]                b_r;
      logic                      r_v;
      logic [31:0]               r_d;
      logic [1:0]                r_r;
   } state_type;

   state_type  s_reg;     // Registered state.
   state_type  s_next;    // Next state.
   logic [1:0] rst_sync;  // Reset release chain.
   logic       rst_n;     // Synchronised reset.

   // Advances the header check over one byte, high bit first.
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
      begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? mac_hdr_pkg::HCS_POLY : 16'h0000);
      end
      return r;
   endfunction

   // Tells whether a byte address hits a register.
   function automatic logic reg_hit(input logic [5:0] a);
      return a == mac_hdr_pkg::REG_CTRL || a == mac_hdr_pkg::REG_TX_HDR || a == mac_hdr_pkg::REG_TX_GO ||
             a == mac_hdr_pkg::REG_STATUS || a == mac_hdr_pkg::REG_MASK || a == mac_hdr_pkg::REG_RX_INFO;
   endfunction

   // Expands byte strobes into a bit mask.
   function automatic logic [31:0] lane_mask(input logic [3:0] st);
      return {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
   endfunction

   // Extended header length carried by a control and parameter byte pair.
   function automatic logic [7:0] ext_len(input logic [7:0] fcb, input logic [7:0] pb);
      return fcb[mac_hdr_pkg::EXT_BIT] ? pb : 8'h00;
   endfunction

   // Bus handshakes and registered outputs.
   assign s_axi_awready      = !s_reg.aw_h;
   assign s_axi_wready       = !s_reg.w_h;
   assign s_axi_arready      = !s_reg.r_v;
   assign s_axi_bvalid       = s_reg.b_v;
   assign s_axi_bresp        = s_reg.b_r;
   assign s_axi_rvalid       = s_reg.r_v;
   assign s_axi_rdata        = s_reg.r_d;
   assign s_axi_rresp        = s_reg.r_r;
   assign irq                = |(s_reg.sts & s_reg.msk);
   assign pdu_valid          = s_reg.o_v;
   assign pdu_data           = s_reg.o_d;
   assign pdu_first          = s_reg.o_first;
   assign pdu_last           = s_reg.o_last;
   assign frame_control_byte = s_reg.fc;
   assign tx_out_valid       = s_reg.t_v;
   assign tx_out_data        = s_reg.t_d;
   assign tx_in_ready        = (!s_reg.t_v || tx_out_ready) &&
                               (s_reg.tx_st == mac_hdr_pkg::T_EH || s_reg.tx_st == mac_hdr_pkg::T_PDU);

   localparam int EV_BITS = mac_hdr_pkg::EV_W; // Width of the event vector.

   // Next-state logic for the bus slave, the parser and the builder.
   always_comb
   begin
      logic [EV_BITS-1:0] ev;
      logic [5:0]         clr;
      logic               go;
      logic               can;
      logic [15:0]        n;
      logic [7:0]         tfc;
      logic [7:0]         tpb;
      logic [15:0]        tn;
      logic [1:0]         ty;
      logic [15:0]        lim;
      logic [31:0]        wm;
      ev  = '0;
      clr = '0;
      go  = 1'b0;
      wm  = lane_mask(s_reg.w_s);
      // Fields of the received header and of the header to send.
      ty  = s_reg.fc[mac_hdr_pkg::TYPE_LSB +: 2];
      n   = s_reg.len - {8'h00, ext_len(s_reg.fc, s_reg.parm)};
      lim = s_reg.ctrl[mac_hdr_pkg::CTRL_VLAN] ? mac_hdr_pkg::PDU_MAX_TAG : mac_hdr_pkg::PDU_MAX;
      tfc = s_reg.tx_hdr[31:24];
      tpb = s_reg.tx_hdr[23:16];
      tn  = s_reg.tx_hdr[15:0] - {8'h00, ext_len(tfc, tpb)};
      can = !s_reg.t_v || tx_out_ready;
      s_next = s_reg;
      // Body markers are only raised together with a forwarded byte.
      s_next.o_v     = 1'b0;
      s_next.o_first = 1'b0;
      s_next.o_last  = 1'b0;
      // Bus: capture address and data in either order.
      if (s_axi_awvalid && !s_reg.aw_h)
      begin
         s_next.aw_h = 1'b1;
         s_next.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_reg.w_h)
      begin
         s_next.w_h = 1'b1;
         s_next.w_d = s_axi_wdata;
         s_next.w_s = s_axi_wstrb;
      end
      if (s_reg.b_v && s_axi_bready)
      begin
         s_next.b_v = 1'b0;
      end
      // Bus: perform a write once both halves are held.
      if (s_reg.aw_h && s_reg.w_h && !s_reg.b_v)
      begin
         s_next.aw_h = 1'b0;
         s_next.w_h  = 1'b0;
         s_next.b_v  = 1'b1;
         s_next.b_r  = reg_hit(s_reg.aw_a) ? mac_hdr_pkg::RESP_OKAY : mac_hdr_pkg::RESP_SLVERR;
         case (s_reg.aw_a)
            mac_hdr_pkg::REG_CTRL:
               s_next.ctrl = (s_reg.ctrl & ~wm[1:0]) | (s_reg.w_d[1:0] & wm[1:0]);
            mac_hdr_pkg::REG_TX_HDR:
               // Header fields hold still while a frame is being built.
               if (s_reg.tx_st == mac_hdr_pkg::T_IDLE)
               begin
                  s_next.tx_hdr = (s_reg.tx_hdr & ~lane_mask(s_reg.w_s)) | (s_reg.w_d & lane_mask(s_reg.w_s));
               end
            mac_hdr_pkg::REG_TX_GO:
               go = s_reg.w_s[0] && s_reg.w_d[0];
            mac_hdr_pkg::REG_STATUS:
               clr = s_reg.w_d[5:0] & wm[5:0];
            mac_hdr_pkg::REG_MASK:
               s_next.msk = (s_reg.msk & ~wm[5:0]) | (s_reg.w_d[5:0] & wm[5:0]);
            default:
               ;
         endcase
      end
      // Bus: reads answer one cycle after the address is taken.
      if (s_reg.r_v && s_axi_rready)
      begin
         s_next.r_v = 1'b0;
      end
      if (s_axi_arvalid && !s_reg.r_v)
      begin
         s_next.r_v = 1'b1;
         s_next.r_r = reg_hit(s_axi_araddr) ? mac_hdr_pkg::RESP_OKAY : mac_hdr_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            mac_hdr_pkg::REG_CTRL:    s_next.r_d = {30'h0, s_reg.ctrl};
            mac_hdr_pkg::REG_TX_HDR:  s_next.r_d = s_reg.tx_hdr;
            mac_hdr_pkg::REG_TX_GO:   s_next.r_d = {31'h0, s_reg.tx_st != mac_hdr_pkg::T_IDLE};
            mac_hdr_pkg::REG_STATUS:  s_next.r_d = {26'h0, s_reg.sts};
            mac_hdr_pkg::REG_MASK:    s_next.r_d = {26'h0, s_reg.msk};
            mac_hdr_pkg::REG_RX_INFO: s_next.r_d = {s_reg.fc, s_reg.parm, s_reg.len};
            default:                  s_next.r_d = 32'h0;
         endcase
      end

      // Receive parser.
      if (rx_valid)
      begin
         case (s_reg.rx_st)
            mac_hdr_pkg::R_FC:
               if (rx_data != mac_hdr_pkg::STUFF_BYTE)
               begin
                  s_next.fc    = rx_data;
                  s_next.crc   = crc_byte(mac_hdr_pkg::HCS_INIT, rx_data);
                  s_next.rx_st = mac_hdr_pkg::R_PARM;
               end
            mac_hdr_pkg::R_PARM:
            begin
               s_next.parm  = rx_data;
               s_next.crc   = crc_byte(s_reg.crc, rx_data);
               s_next.rx_st = mac_hdr_pkg::R_LH;
            end
            mac_hdr_pkg::R_LH:
            begin
               s_next.len[15:8] = rx_data;
               s_next.crc       = crc_byte(s_reg.crc, rx_data);
               s_next.rx_st     = mac_hdr_pkg::R_LL;
            end
            mac_hdr_pkg::R_LL:
            begin
               s_next.len[7:0] = rx_data;
               s_next.crc      = crc_byte(s_reg.crc, rx_data);
               s_next.cnt      = {8'h00, ext_len(s_reg.fc, s_reg.parm)};
               s_next.rx_st    = (ext_len(s_reg.fc, s_reg.parm) != 8'h00) ? mac_hdr_pkg::R_EH : mac_hdr_pkg::R_H1;
            end
            mac_hdr_pkg::R_EH:
            begin
               s_next.crc = crc_byte(s_reg.crc, rx_data);
               s_next.cnt = s_reg.cnt - 16'h0001;
               if (s_reg.cnt == 16'h0001)
               begin
                  s_next.rx_st = mac_hdr_pkg::R_H1;
               end
            end
            mac_hdr_pkg::R_H1:
            begin
               s_next.hcs_hi = rx_data;
               s_next.rx_st  = mac_hdr_pkg::R_H2;
            end
            mac_hdr_pkg::R_H2:
            begin
               s_next.rx_st  = mac_hdr_pkg::R_FC;
               s_next.cnt    = n;
               s_next.bfirst = 1'b1;
               s_next.keep   = (ty == mac_hdr_pkg::TYPE_MAC) ||
                               (ty == mac_hdr_pkg::TYPE_PKT && s_reg.fc[mac_hdr_pkg::PARM_LSB +: 5] == mac_hdr_pkg::PARM_PKT);
               if ({s_reg.hcs_hi, rx_data} != s_reg.crc)
               begin
                  ev[mac_hdr_pkg::EV_HCS] = 1'b1;
               end
               else if (ty == mac_hdr_pkg::TYPE_MAC && (s_reg.fc[mac_hdr_pkg::PARM_LSB +: 5] == mac_hdr_pkg::PARM_REQ ||
                        s_reg.fc[mac_hdr_pkg::PARM_LSB +: 5] == mac_hdr_pkg::PARM_CONCAT))
               begin
                  // Request carries no body; a concatenation is followed by embedded headers.
                  ev[mac_hdr_pkg::EV_DONE] = 1'b1;
               end
               else if (ext_len(s_reg.fc, s_reg.parm) > mac_hdr_pkg::EXT_HEADER_BLOCK_MAX ||
                        s_reg.len < {8'h00, ext_len(s_reg.fc, s_reg.parm)})
               begin
                  ev[mac_hdr_pkg::EV_SIZE] = 1'b1;
               end
               else
               begin
                  if (ty == mac_hdr_pkg::TYPE_PKT && (n > lim ||
                      (!s_reg.ctrl[mac_hdr_pkg::CTRL_HEADEND] && n < mac_hdr_pkg::PDU_MIN_DS)))
                  begin
                     s_next.keep             = 1'b0;
                     ev[mac_hdr_pkg::EV_SIZE] = 1'b1;
                  end
                  else
                  begin
                     ev[mac_hdr_pkg::EV_DONE] = s_next.keep;
                     ev[mac_hdr_pkg::EV_SKIP] = !s_next.keep;
                  end
                  if (n != 16'h0000)
                  begin
                     s_next.rx_st = mac_hdr_pkg::R_BODY;
                  end
               end
            end
            mac_hdr_pkg::R_BODY:
            begin
               // Kept bodies pass unchanged, CRC included; others are skipped by count.
               s_next.o_v     = s_reg.keep;
               s_next.o_d     = rx_data;
               s_next.o_first = s_reg.keep && s_reg.bfirst;
               s_next.o_last  = s_reg.keep && s_reg.cnt == 16'h0001;
               s_next.bfirst  = 1'b0;
               s_next.cnt     = s_reg.cnt - 16'h0001;
               if (s_reg.cnt == 16'h0001)
               begin
                  s_next.rx_st = mac_hdr_pkg::R_FC;
               end
            end
            default:
               s_next.rx_st = mac_hdr_pkg::R_FC;
         endcase
      end

      // Transmit builder.
      if (s_reg.t_v && tx_out_ready)
      begin
         s_next.t_v = 1'b0;
      end
      case (s_reg.tx_st)
         mac_hdr_pkg::T_IDLE:
            if (go)
            begin
               if (tfc == mac_hdr_pkg::STUFF_BYTE ||
                   (tfc[mac_hdr_pkg::TYPE_LSB +: 2] == mac_hdr_pkg::TYPE_PKT &&
                    tfc[mac_hdr_pkg::PARM_LSB +: 5] != mac_hdr_pkg::PARM_PKT) ||
                   (tfc[mac_hdr_pkg::TYPE_LSB +: 2] != mac_hdr_pkg::TYPE_MAC && !tfc[mac_hdr_pkg::EXT_BIT] &&
                    tpb != 8'h00) || ext_len(tfc, tpb) > mac_hdr_pkg::EXT_HEADER_BLOCK_MAX ||
                   s_reg.tx_hdr[15:0] < {8'h00, ext_len(tfc, tpb)} ||
                   (tfc[mac_hdr_pkg::TYPE_LSB +: 2] == mac_hdr_pkg::TYPE_PKT && (tn > lim ||
                    (s_reg.ctrl[mac_hdr_pkg::CTRL_HEADEND] && tn < mac_hdr_pkg::PDU_MIN_DS))))
               begin
                  ev[mac_hdr_pkg::EV_TXBAD] = 1'b1;
               end
               else
               begin
                  s_next.tx_st = mac_hdr_pkg::T_FC;
               end
            end
         mac_hdr_pkg::T_FC, mac_hdr_pkg::T_PARM, mac_hdr_pkg::T_LH, mac_hdr_pkg::T_LL:
            if (can)
            begin
               // Header bytes go out control first, length high octet first.
               s_next.t_v = 1'b1;
               case (s_reg.tx_st)
                  mac_hdr_pkg::T_FC:   s_next.t_d = tfc;
                  mac_hdr_pkg::T_PARM: s_next.t_d = tpb;
                  mac_hdr_pkg::T_LH:   s_next.t_d = s_reg.tx_hdr[15:8];
                  default:             s_next.t_d = s_reg.tx_hdr[7:0];
               endcase
               s_next.tcrc  = crc_byte((s_reg.tx_st == mac_hdr_pkg::T_FC) ? mac_hdr_pkg::HCS_INIT : s_reg.tcrc,
                                       s_next.t_d);
               s_next.tcnt  = {8'h00, ext_len(tfc, tpb)};
               s_next.tx_st = (s_reg.tx_st == mac_hdr_pkg::T_LL) ?
                              ((ext_len(tfc, tpb) != 8'h00) ? mac_hdr_pkg::T_EH : mac_hdr_pkg::T_H1) :
                              mac_hdr_pkg::tx_state_type'(s_reg.tx_st + 4'h1);
            end
         mac_hdr_pkg::T_EH:
            if (can && tx_in_valid)
            begin
               s_next.t_v  = 1'b1;
               s_next.t_d  = tx_in_data;
               s_next.tcrc = crc_byte(s_reg.tcrc, tx_in_data);
               s_next.tcnt = s_reg.tcnt - 16'h0001;
               if (s_reg.tcnt == 16'h0001)
               begin
                  s_next.tx_st = mac_hdr_pkg::T_H1;
               end
            end
         mac_hdr_pkg::T_H1:
            if (can)
            begin
               s_next.t_v   = 1'b1;
               s_next.t_d   = s_reg.tcrc[15:8];
               s_next.tx_st = mac_hdr_pkg::T_H2;
            end
         mac_hdr_pkg::T_H2:
            if (can)
            begin
               s_next.t_v   = 1'b1;
               s_next.t_d   = s_reg.tcrc[7:0];
               s_next.tcnt  = tn;
               s_next.tx_st = (tn == 16'h0000) ? mac_hdr_pkg::T_IDLE : mac_hdr_pkg::T_PDU;
               ev[mac_hdr_pkg::EV_TXEND] = tn == 16'h0000;
            end
         mac_hdr_pkg::T_PDU:
            if (can && tx_in_valid && !payload_header_squash)
            begin
               // Bytes pass untouched; squashed bytes are taken and dropped.
               s_next.t_v  = 1'b1;
               s_next.t_d  = tx_in_data;
               s_next.tcnt = s_reg.tcnt - 16'h0001;
               if (s_reg.tcnt == 16'h0001)
               begin
                  s_next.tx_st = mac_hdr_pkg::T_IDLE;
                  ev[mac_hdr_pkg::EV_TXEND] = 1'b1;
               end
            end
         default:
            s_next.tx_st = mac_hdr_pkg::T_IDLE;
      endcase

      // Sticky events: a new event wins over a clear in the same cycle.
      s_next.sts = (s_reg.sts & ~clr) | ev;
   end

   // Reset release through two flip-flops.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_sync <= 2'h0;
      end
      else
      begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // State register.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg        <= '0;
         s_reg.ctrl   <= mac_hdr_pkg::CTRL_RST;
         s_reg.tx_hdr <= mac_hdr_pkg::TX_HDR_RST;
         s_reg.msk    <= mac_hdr_pkg::MASK_RST;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

endmodule // mac_hdr_framer

// *** src/mac_hdr_pkg.sv ***
// Constants, field layout, register map and state types of the MAC header framer.
package mac_hdr_pkg;
   // Frame control byte layout.
   localparam int          TYPE_LSB    = 6;
   localparam int          PARM_LSB    = 1;
   localparam int          EXT_BIT     = 0;
   // Frame type codes.
   localparam logic [1:0]  TYPE_PKT    = 2'h0;
   localparam logic [1:0]  TYPE_MAC    = 2'h3;
   // Parameter codes under the packet and MAC-specific types.
   localparam logic [4:0]  PARM_PKT    = 5'h00;
   localparam logic [4:0]  PARM_REQ    = 5'h02;
   localparam logic [4:0]  PARM_CONCAT = 5'h1C;
   // Stuff byte and size limits.
   localparam logic [7:0]  STUFF_BYTE  = 8'hFF;
   localparam logic [7:0]  EXT_HEADER_BLOCK_MAX    = 8'hF0;
   localparam logic [15:0] PDU_MAX     = 16'h05EE;
   localparam logic [15:0] PDU_MAX_TAG = 16'h05F2;
   localparam logic [15:0] PDU_MIN_DS  = 16'h000C;
   // Header check polynomial and start value.
   localparam logic [15:0] HCS_POLY    = 16'h1021;
   localparam logic [15:0] HCS_INIT    = 16'hFFFF;
   // Register byte offsets.
   localparam logic [5:0]  REG_CTRL    = 6'h00;
   localparam logic [5:0]  REG_TX_HDR  = 6'h04;
   localparam logic [5:0]  REG_TX_GO   = 6'h08;
   localparam logic [5:0]  REG_STATUS  = 6'h0C;
   localparam logic [5:0]  REG_MASK    = 6'h10;
   localparam logic [5:0]  REG_RX_INFO = 6'h14;
   // Control bits and reset values.
   localparam int          CTRL_HEADEND = 0;
   localparam int          CTRL_VLAN    = 1;
   localparam logic [1:0]  CTRL_RST     = 2'h0;
   localparam logic [31:0] TX_HDR_RST   = 32'h0;
   localparam logic [5:0]  MASK_RST     = 6'h00;
   // Status event bits.
   localparam int          EV_HCS   = 0;
   localparam int          EV_DONE  = 1;
   localparam int          EV_SKIP  = 2;
   localparam int          EV_SIZE  = 3;
   localparam int          EV_TXEND = 4;
   localparam int          EV_TXBAD = 5;
   localparam int          EV_W     = 6;
   // Bus answers.
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // Receive parser states.
   typedef enum logic [2:0] {R_FC, R_PARM, R_LH, R_LL, R_EH, R_H1, R_H2, R_BODY} rx_state_type;
   // Transmit builder states.
   typedef enum logic [3:0] {T_IDLE, T_FC, T_PARM, T_LH, T_LL, T_EH, T_H1, T_H2, T_PDU} tx_state_type;
endpackage

// *** sim/mac_hdr_framer_properties.sv ***
// Port checker of the MAC header framer.
`timescale 1ns/10ps
module mac_hdr_framer_properties (
   input wire logic        ref_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_bvalid, s_axi_bready,
   input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready, rx_valid,
   input wire logic        pdu_valid, pdu_first, pdu_last, tx_out_valid, tx_out_ready,
   input wire logic [7:0]  frame_control_byte, tx_out_data
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // A framed byte offered to the link and not yet taken.
   sequence tx_wait;
      tx_out_valid && !tx_out_ready;
   endsequence
   chk_tx_hold: assert property (tx_wait |=> tx_out_valid && $stable(tx_out_data))
      else $error("link byte moved");
   chk_pdu_lat: assert property (pdu_valid |-> $past(rx_valid))
      else $error("body byte without input");
   chk_mark_qual: assert property (pdu_first || pdu_last |-> pdu_valid)
      else $error("marker alone");
   chk_no_stuff: assert property (frame_control_byte != 8'hFF)
      else $error("stuff byte as control");
   chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer kept");
   chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer kept");
   chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("write address taken while busy");
endmodule // mac_hdr_framer_properties
bind mac_hdr_framer mac_hdr_framer_properties chk (.*);

// *** sim/peer_link_sink.sv ***
// Far-side peer that takes framed bytes, promptly or with stalls.
`timescale 1ns/10ps
module peer_link_sink (
   input wire logic        ref_clk, tx_out_valid, slow,
   input wire logic [7:0]  tx_out_data,
   output logic            tx_out_ready
);
   logic [7:0] q[$];   // Bytes in link order, high octet first.
   logic       t = 1'h0; // Toggle that paces a stalling peer.
   always @(posedge ref_clk)
   begin
      if (tx_out_valid && tx_out_ready)
         q.push_back(tx_out_data);
      t <= ~t;
   end
   assign tx_out_ready = !slow || t;
endmodule // peer_link_sink

// *** sim/mac_hdr_framer_tb.sv ***
// Self-checking bench of the MAC header framer.
`timescale 1ns/10ps
module mac_hdr_framer_tb;
   logic ref_clk = 1'h0, arst_n = 1'h0, rx_valid = 1'h0, tx_in_valid = 1'h0, slow = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, payload_header_squash = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, irq;
   logic s_axi_arready, s_axi_rvalid, pdu_valid, pdu_first, pdu_last, tx_in_ready, tx_out_valid, tx_out_ready;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0] rx_data = 8'h00, tx_in_data = 8'h00, pdu_data, frame_control_byte, tx_out_data;
   logic [19:0] plog = 20'h0; // Markers and data of the last two body bytes.
   int errors = 0, compares = 0, npdu = 0;
   mac_hdr_framer uut (.*);
   peer_link_sink peer (.*);
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (pdu_valid)
      begin
         npdu <= npdu + 1;
         plog <= {plog[9:0], pdu_first, pdu_last, pdu_data};
      end
   // Header check: CCITT polynomial, all-ones start, high bit first.
   function automatic logic [15:0] header_check_word(input logic [31:0] h);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 31; i >= 0; i--)
         c = {c[14:0], 1'h0} ^ ((c[15] ^ h[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // One register access; each channel is released at the edge that takes it.
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (n = 0; n < 50 && !(w ? s_axi_bvalid : s_axi_rvalid); n++)
      begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      q = s_axi_rdata;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
      if (n == 50) errors++;
      if (n == 50) end_of_test();
   endtask
   task automatic rxb(input logic [7:0] b);
      @(posedge ref_clk);
      rx_valid <= 1'h1;
      rx_data <= b;
   endtask
   // Stuff byte, header, check word, then nb body bytes.
   task automatic rxf(input logic [31:0] h, input logic [15:0] c, input int nb);
      rxb(8'hFF);
      for (int i = 3; i >= 0; i--)
         rxb(h[i*8 +: 8]);
      rxb(c[15:8]);
      rxb(c[7:0]);
      for (int i = 0; i < nb; i++)
         rxb(8'hA0 + 8'(i));
      @(posedge ref_clk);
      rx_valid <= 1'h0;
   endtask
   // Reads, checks and clears the event status, and checks the interrupt.
   task automatic st(input logic [31:0] e, input logic i);
      repeat (3) @(posedge ref_clk);
      bus(0, mac_hdr_pkg::REG_STATUS, 32'h0);
      chk("status", e, q);
      chk("irq", {31'h0, i}, {31'h0, irq});
      bus(1, mac_hdr_pkg::REG_STATUS, 32'h3F);
      chk("irq clr", 32'h0, {31'h0, irq});
   endtask
   task automatic t_regs();
      bus(0, mac_hdr_pkg::REG_CTRL, 32'h0);
      chk("ctrl", 32'h0, q);
      bus(0, 6'h3C, 32'h0);
      chk("unmapped", {30'h0, mac_hdr_pkg::RESP_SLVERR}, {q[29:0], rsp});
      bus(1, mac_hdr_pkg::REG_MASK, 32'h3F);
      bus(0, mac_hdr_pkg::REG_MASK, 32'h0);
      chk("mask", 32'h3F, q);
      $display("regs done");
   endtask
   task automatic t_tx();
      int n;
      slow <= 1'h1;
      bus(1, mac_hdr_pkg::REG_TX_HDR, 32'h0);
      bus(1, mac_hdr_pkg::REG_TX_GO, 32'h1);
      for (n = 0; n < 100 && peer.q.size() < 6; n++)
         @(posedge ref_clk);
      if (n == 100) errors++;
      if (n == 100) end_of_test();
      chk("tx head", 32'h0, {peer.q[0], peer.q[1], peer.q[2], peer.q[3]});
      chk("tx hcs", {16'h0, header_check_word(32'h0)}, {16'h0, peer.q[4], peer.q[5]});
      st(32'h10, 1'h1);
      bus(1, mac_hdr_pkg::REG_MASK, 32'h0);
      bus(1, mac_hdr_pkg::REG_TX_HDR, 32'hFF000000);
      bus(1, mac_hdr_pkg::REG_TX_GO, 32'h1);
      st(32'h20, 1'h0);
      $display("tx done");
   endtask
   task automatic t_rx();
      logic [7:0] f[3] = '{8'h40, 8'h80, 8'h02};
      int n0;
      n0 = npdu;
      bus(1, mac_hdr_pkg::REG_CTRL, 32'h1);
      rxf(32'h2, header_check_word(32'h2), 2);
      st(32'h2, 1'h0);
      chk("pdu count", 32'h2, npdu - n0);
      chk("pdu bytes", 32'hA81A1, {12'h0, plog});
      bus(0, mac_hdr_pkg::REG_RX_INFO, 32'h0);
      chk("rx info", 32'h2, q);
      foreach (f[i])
         rxf({f[i], 24'h2}, header_check_word({f[i], 24'h2}), 2);
      st(32'h4, 1'h0);
      chk("skip count", 32'h2, npdu - n0);
      chk("fc", 32'h2, {24'h0, frame_control_byte});
      rxf(32'h2, ~header_check_word(32'h2), 0);
      st(32'h1, 1'h0);
      $display("rx done");
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'h1;
      repeat (3) @(posedge ref_clk);
      t_regs();
      t_tx();
      t_rx();
      end_of_test();
   end
endmodule // mac_hdr_framer_tb
